// ---- hdl/spt_down_counter.sv ----
`timescale 1ns/100ps
`include "spt_defs.svh"

module spt_down_counter #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic tick,
    input wire logic restart,
    input wire logic hard_reset,
    input wire logic [W-1:0] period,
    // Software write
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    // Status
    output logic [W-1:0] count,
    output logic underflow
);

    logic at_bottom;

    assign at_bottom = (count == '0);
    assign underflow = tick && at_bottom && !wr_en && !hard_reset
        && !restart;

    // Software write beats every other update in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (wr_en) begin
            count <= wr_data;
        end else if (hard_reset) begin
            count <= '0;
        end else if (restart) begin
            count <= period;
        end else if (tick) begin
            count <= at_bottom ? period : W'(count - 1'b1);
        end
    end

endmodule : spt_down_counter

// ---- hdl/spt_prescaler.sv ----
`timescale 1ns/100ps
`include "spt_defs.svh"

module spt_prescaler #(
    parameter int DIV_W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] select,
    // Count clock enable
    output logic tick
);

    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] mask;

    function automatic logic [DIV_W-1:0] divide_mask(input logic [2:0] sel);
        logic [10:0] ratio;
        ratio = `SPT_DIV1;
        case (sel)
            3'h0: ratio = `SPT_DIV1;
            3'h1: ratio = `SPT_DIV2;
            3'h2: ratio = `SPT_DIV4;
            3'h3: ratio = `SPT_DIV8;
            3'h4: ratio = `SPT_DIV16;
            3'h5: ratio = `SPT_DIV64;
            3'h6: ratio = `SPT_DIV256;
            3'h7: ratio = `SPT_DIV1024;
        endcase
        divide_mask = DIV_W'(ratio - 11'h001);
    endfunction : divide_mask

    assign mask = divide_mask(select);
    // Tick when all low bits under the mask are ones
    assign tick = run && ((count & mask) == mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (restart || !run) begin
            count <= '0;
        end else begin
            count <= DIV_W'(count + 1'b1);
        end
    end

endmodule : spt_prescaler

// ---- hdl/spt_split_timer_control.sv ----
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "spt_defs.svh"

module spt_split_timer_control #(
    parameter int CHANNELS = 3,
    parameter int DIV_W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port output register, low channels then high channels
    input wire logic [2*CHANNELS-1:0] port_out,
    // Waveform outputs
    output logic [2*CHANNELS-1:0] waveform_pin,
    output logic [2*CHANNELS-1:0] waveform_ccl,
    // Interrupt request lines
    output logic [CHANNELS-1:0] irq_low_compare,
    output logic irq_high_underflow,
    output logic irq_low_underflow
);

    // Control state
    logic enable;
    logic [2:0] prescaler_select;
    logic split_mode_bit;
    logic [CHANNELS-1:0] low_output_enable;
    logic [CHANNELS-1:0] high_output_enable;
    logic [CHANNELS-1:0] low_output_override_value;
    logic [CHANNELS-1:0] high_output_override_value;
    logic [1:0] command_target_select;
    logic [CHANNELS-1:0] low_compare_interrupt_en;
    logic high_underflow_en;
    logic low_underflow_en;
    logic [CHANNELS-1:0] low_compare_interrupt;
    logic high_underflow;
    logic low_underflow;
    logic [7:0] low_period;
    logic [7:0] high_period;
    logic [7:0] low_compare [CHANNELS];
    logic [7:0] high_compare [CHANNELS];
    logic [CHANNELS-1:0] low_wave;
    logic [CHANNELS-1:0] high_wave;
    logic pslverr_q;

    // Counter state
    logic [7:0] low_counter_value;
    logic [7:0] high_counter_value;
    logic low_bottom;
    logic high_bottom;
    logic count_tick;

    function automatic logic index_hit(input logic [7:0] addr,
                                       input logic [5:0] idx);
        index_hit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
    endfunction : index_hit

    // Bus decode
    wire wr_access = psel && penable && pwrite;
    wire rd_setup = psel && !penable;
    wire wr_ctrl = wr_access && index_hit(paddr, `SPT_IDX_CTRL);
    wire wr_out_en = wr_access && index_hit(paddr, `SPT_IDX_OUT_EN);
    wire wr_out_val = wr_access && index_hit(paddr, `SPT_IDX_OUT_VAL);
    wire wr_mode = wr_access && index_hit(paddr, `SPT_IDX_MODE);
    wire wr_cmd_clr = wr_access && index_hit(paddr, `SPT_IDX_CMD_CLR);
    wire wr_cmd_set = wr_access && index_hit(paddr, `SPT_IDX_CMD_SET);
    wire wr_int_en = wr_access && index_hit(paddr, `SPT_IDX_INT_EN);
    wire wr_int_flag = wr_access && index_hit(paddr, `SPT_IDX_INT_FLAG);
    wire wr_low_cnt = wr_access && index_hit(paddr, `SPT_IDX_LOW_CNT);
    wire wr_high_cnt = wr_access && index_hit(paddr, `SPT_IDX_HIGH_CNT);
    wire wr_low_per = wr_access && index_hit(paddr, `SPT_IDX_LOW_PER);
    wire wr_high_per = wr_access && index_hit(paddr, `SPT_IDX_HIGH_PER);
    wire [7:0] wbyte = pwdata[7:0];

    // Commands act only when both counters are targeted
    wire [1:0] cmd_target = command_target_select
        | wbyte[`SPT_COMMAND_TARGET_SELECT_LSB +: 2];
    wire [1:0] cmd_code = wbyte[`SPT_CMD_LSB +: 2];
    wire cmd_valid = wr_cmd_set
        && (cmd_target == spt_pkg::spt_target_both);
    wire restart_pulse = cmd_valid
        && (cmd_code == spt_pkg::spt_cmd_restart);
    wire hard_reset_pulse = cmd_valid && !enable
        && (cmd_code == spt_pkg::spt_cmd_hard_reset);

    // Split counting only while enabled and split selected
    wire running = enable && split_mode_bit;

    spt_prescaler #(
        .DIV_W(DIV_W)
    ) u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .run(running),
        .restart(restart_pulse),
        .select(prescaler_select),
        .tick(count_tick)
    );

    spt_down_counter #(
        .W(8)
    ) u_low_counter (
        .pclk(pclk),
        .presetn(presetn),
        .tick(count_tick),
        .restart(restart_pulse),
        .hard_reset(hard_reset_pulse),
        .period(low_period),
        .wr_en(wr_low_cnt),
        .wr_data(wbyte),
        .count(low_counter_value),
        .underflow(low_bottom)
    );

    spt_down_counter #(
        .W(8)
    ) u_high_counter (
        .pclk(pclk),
        .presetn(presetn),
        .tick(count_tick),
        .restart(restart_pulse),
        .hard_reset(hard_reset_pulse),
        .period(high_period),
        .wr_en(wr_high_cnt),
        .wr_data(wbyte),
        .count(high_counter_value),
        .underflow(high_bottom)
    );

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= 1'b0;
            prescaler_select <= 3'h0;
        end else if (wr_ctrl) begin
            enable <= wbyte[`SPT_ENABLE_BIT];
            prescaler_select <= wbyte[`SPT_PRESCALER_SELECT_LSB +: 3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_output_enable <= '0;
            high_output_enable <= '0;
        end else if (wr_out_en) begin
            low_output_enable <= wbyte[`SPT_LOW_LSB +: CHANNELS];
            high_output_enable <= wbyte[`SPT_HIGH_LSB +: CHANNELS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_output_override_value <= '0;
            high_output_override_value <= '0;
        end else if (wr_out_val) begin
            low_output_override_value <= wbyte[`SPT_LOW_LSB +: CHANNELS];
            high_output_override_value <= wbyte[`SPT_HIGH_LSB +: CHANNELS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            split_mode_bit <= 1'b0;
        end else if (wr_mode) begin
            split_mode_bit <= wbyte[`SPT_SPLIT_BIT];
        end
    end

    // Set and clear views of the target field; no read-modify-write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_target_select <= 2'h0;
        end else if (wr_cmd_set) begin
            command_target_select <= cmd_target;
        end else if (wr_cmd_clr) begin
            command_target_select <= command_target_select
                & ~wbyte[`SPT_COMMAND_TARGET_SELECT_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_compare_interrupt_en <= '0;
            high_underflow_en <= 1'b0;
            low_underflow_en <= 1'b0;
        end else if (wr_int_en) begin
            low_compare_interrupt_en <= wbyte[`SPT_LCMP_LSB +: CHANNELS];
            high_underflow_en <= wbyte[`SPT_HIGH_UNDERFLOW_BIT];
            low_underflow_en <= wbyte[`SPT_LOW_UNDERFLOW_BIT];
        end
    end

    // Period registers; a hard reset restores them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_period <= `SPT_RST_PER;
            high_period <= `SPT_RST_PER;
        end else begin
            if (wr_low_per) begin
                low_period <= wbyte;
            end else if (hard_reset_pulse) begin
                low_period <= `SPT_RST_PER;
            end
            if (wr_high_per) begin
                high_period <= wbyte;
            end else if (hard_reset_pulse) begin
                high_period <= `SPT_RST_PER;
            end
        end
    end

    // Per-channel compare registers, match flags and waveforms
    logic [CHANNELS-1:0] low_match;
    logic [CHANNELS-1:0] high_match;

    for (genvar n = 0; n < CHANNELS; n++) begin : g_channel
        wire wr_low_cmp = wr_access
            && index_hit(paddr, 6'(`SPT_IDX_LOW_CMP0 + 2 * n));
        wire wr_high_cmp = wr_access
            && index_hit(paddr, 6'(`SPT_IDX_HIGH_CMP0 + 2 * n));

        assign low_match[n] = count_tick
            && (low_counter_value == low_compare[n]);
        assign high_match[n] = count_tick
            && (high_counter_value == high_compare[n]);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                low_compare[n] <= `SPT_RST_BYTE;
                high_compare[n] <= `SPT_RST_BYTE;
            end else begin
                if (wr_low_cmp) begin
                    low_compare[n] <= wbyte;
                end else if (hard_reset_pulse) begin
                    low_compare[n] <= `SPT_RST_BYTE;
                end
                if (wr_high_cmp) begin
                    high_compare[n] <= wbyte;
                end else if (hard_reset_pulse) begin
                    high_compare[n] <= `SPT_RST_BYTE;
                end
            end
        end

        // Waveform set at match, cleared at bottom; tracks value when idle
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                low_wave[n] <= 1'b0;
                high_wave[n] <= 1'b0;
            end else if (!enable) begin
                low_wave[n] <= low_output_override_value[n];
                high_wave[n] <= high_output_override_value[n];
            end else if (restart_pulse) begin
                low_wave[n] <= 1'b0;
                high_wave[n] <= 1'b0;
            end else begin
                if (count_tick && low_counter_value == low_compare[n]) begin
                    low_wave[n] <= 1'b1;
                end else if (low_bottom) begin
                    low_wave[n] <= 1'b0;
                end
                if (high_match[n]) begin
                    high_wave[n] <= 1'b1;
                end else if (high_bottom) begin
                    high_wave[n] <= 1'b0;
                end
            end
        end

        // Stopped timer shows the value bits directly
        wire low_cmp_out = enable ? low_wave[n]
            : low_output_override_value[n];
        wire high_cmp_out = enable ? high_wave[n]
            : high_output_override_value[n];

        // Pad takes timer output only in split mode where enabled, else port value
        assign waveform_pin[n] = (split_mode_bit && low_output_enable[n])
            ? low_cmp_out : port_out[n];
        assign waveform_pin[n+CHANNELS] =
            (split_mode_bit && high_output_enable[n])
            ? high_cmp_out : port_out[n+CHANNELS];
        assign waveform_ccl[n] = low_cmp_out;
        assign waveform_ccl[n+CHANNELS] = high_cmp_out;
    end

    // Sticky flags; a new event beats a clear in the same cycle
    wire [7:0] flag_clear = wr_int_flag ? wbyte : 8'h00;
    // Only a real count match sets a compare flag, not bottom itself
    wire [CHANNELS-1:0] low_cmp_event = low_match;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_compare_interrupt <= '0;
            high_underflow <= 1'b0;
            low_underflow <= 1'b0;
        end else begin
            low_compare_interrupt <= (low_compare_interrupt
                & ~flag_clear[`SPT_LCMP_LSB +: CHANNELS])
                | low_cmp_event;
            high_underflow <= (high_underflow
                & ~flag_clear[`SPT_HIGH_UNDERFLOW_BIT]) | high_bottom;
            low_underflow <= (low_underflow
                & ~flag_clear[`SPT_LOW_UNDERFLOW_BIT]) | low_bottom;
        end
    end

    assign irq_low_compare = low_compare_interrupt
        & low_compare_interrupt_en;
    assign irq_high_underflow = high_underflow && high_underflow_en;
    assign irq_low_underflow = low_underflow && low_underflow_en;

    // Read selection
    logic [7:0] read_byte;
    logic read_mapped;
    logic [7:0] cmp_byte;
    logic cmp_hit;

    always_comb begin
        cmp_byte = 8'h00;
        cmp_hit = 1'b0;
        for (int n = 0; n < CHANNELS; n++) begin
            if (index_hit(paddr, 6'(`SPT_IDX_LOW_CMP0 + 2 * n))) begin
                cmp_byte = low_compare[n];
                cmp_hit = 1'b1;
            end
            if (index_hit(paddr, 6'(`SPT_IDX_HIGH_CMP0 + 2 * n))) begin
                cmp_byte = high_compare[n];
                cmp_hit = 1'b1;
            end
        end
    end

    always_comb begin
        read_byte = 8'h00;
        read_mapped = 1'b1;
        if (paddr[1:0] != 2'b00) begin
            read_mapped = 1'b0;
        end else if (cmp_hit) begin
            read_byte = cmp_byte;
        end else begin
            case (paddr[7:2])
                `SPT_IDX_CTRL: begin
                    read_byte[`SPT_ENABLE_BIT] = enable;
                    read_byte[`SPT_PRESCALER_SELECT_LSB +: 3] = prescaler_select;
                end
                `SPT_IDX_OUT_EN: begin
                    read_byte[`SPT_LOW_LSB +: CHANNELS] = low_output_enable;
                    read_byte[`SPT_HIGH_LSB +: CHANNELS] = high_output_enable;
                end
                `SPT_IDX_OUT_VAL: begin
                    read_byte[`SPT_LOW_LSB +: CHANNELS] =
                        low_output_override_value;
                    read_byte[`SPT_HIGH_LSB +: CHANNELS] =
                        high_output_override_value;
                end
                `SPT_IDX_MODE: read_byte[`SPT_SPLIT_BIT] = split_mode_bit;
                // Command bits stay zero on read
                `SPT_IDX_CMD_CLR, `SPT_IDX_CMD_SET: begin
                    read_byte[`SPT_COMMAND_TARGET_SELECT_LSB +: 2] =
                        command_target_select;
                end
                `SPT_IDX_INT_EN: begin
                    read_byte[`SPT_LCMP_LSB +: CHANNELS] =
                        low_compare_interrupt_en;
                    read_byte[`SPT_HIGH_UNDERFLOW_BIT] = high_underflow_en;
                    read_byte[`SPT_LOW_UNDERFLOW_BIT] = low_underflow_en;
                end
                `SPT_IDX_INT_FLAG: begin
                    read_byte[`SPT_LCMP_LSB +: CHANNELS] =
                        low_compare_interrupt;
                    read_byte[`SPT_HIGH_UNDERFLOW_BIT] = high_underflow;
                    read_byte[`SPT_LOW_UNDERFLOW_BIT] = low_underflow;
                end
                `SPT_IDX_LOW_CNT: read_byte = low_counter_value;
                `SPT_IDX_HIGH_CNT: read_byte = high_counter_value;
                `SPT_IDX_LOW_PER: read_byte = low_period;
                `SPT_IDX_HIGH_PER: read_byte = high_period;
                default: read_mapped = 1'b0;
            endcase
        end
    end

    // Data captured in setup, so access needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, read_byte};
            pslverr_q <= !read_mapped;
        end
    end

    assign pready = 1'b1;
    assign pslverr = pslverr_q && psel && penable;

endmodule : spt_split_timer_control

// ---- shared/spt_defs.svh ----
`ifndef SPT_DEFS_SVH
`define SPT_DEFS_SVH

// Register indices; byte address is four times the index
`define SPT_IDX_CTRL 6'h00
`define SPT_IDX_OUT_EN 6'h01
`define SPT_IDX_OUT_VAL 6'h02
`define SPT_IDX_MODE 6'h03
`define SPT_IDX_CMD_CLR 6'h04
`define SPT_IDX_CMD_SET 6'h05
`define SPT_IDX_INT_EN 6'h0a
`define SPT_IDX_INT_FLAG 6'h0b
`define SPT_IDX_LOW_CNT 6'h20
`define SPT_IDX_HIGH_CNT 6'h21
`define SPT_IDX_LOW_PER 6'h26
`define SPT_IDX_HIGH_PER 6'h27
`define SPT_IDX_LOW_CMP0 6'h28
`define SPT_IDX_HIGH_CMP0 6'h29

// Field positions
`define SPT_ENABLE_BIT 0
`define SPT_PRESCALER_SELECT_LSB 1
`define SPT_LOW_LSB 0
`define SPT_HIGH_LSB 4
`define SPT_SPLIT_BIT 0
`define SPT_COMMAND_TARGET_SELECT_LSB 0
`define SPT_CMD_LSB 2
`define SPT_LOW_UNDERFLOW_BIT 0
`define SPT_HIGH_UNDERFLOW_BIT 1
`define SPT_LCMP_LSB 4

// Reset values
`define SPT_RST_BYTE 8'h00
`define SPT_RST_PER 8'hff

// Prescaler division ratios
`define SPT_DIV1 11'h001
`define SPT_DIV2 11'h002
`define SPT_DIV4 11'h004
`define SPT_DIV8 11'h008
`define SPT_DIV16 11'h010
`define SPT_DIV64 11'h040
`define SPT_DIV256 11'h100
`define SPT_DIV1024 11'h400

`endif

// ---- shared/spt_pkg.sv ----
package spt_pkg;

    typedef enum logic [1:0] {
        spt_cmd_none = 2'b00,
        spt_cmd_reserved = 2'b01,
        spt_cmd_restart = 2'b10,
        spt_cmd_hard_reset = 2'b11
    } spt_command_t;

    typedef enum logic [1:0] {
        spt_target_none = 2'b00,
        spt_target_rsvd_a = 2'b01,
        spt_target_rsvd_b = 2'b10,
        spt_target_both = 2'b11
    } spt_target_t;

endpackage : spt_pkg

// ---- test/spt_checker_properties.sv ----
`timescale 1ns/100ps
module spt_checker #(
    parameter int CHANNELS = 3
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Pins
    input wire logic [2*CHANNELS-1:0] port_out,
    input wire logic [2*CHANNELS-1:0] waveform_pin,
    input wire logic [2*CHANNELS-1:0] waveform_ccl,
    // Interrupts
    input wire logic [CHANNELS-1:0] irq_low_compare,
    input wire logic irq_high_underflow,
    input wire logic irq_low_underflow
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    // Shadows of software-written registers
    logic [7:0] ct, oe, ov;
    logic sp;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) {ct, oe, ov, sp} <= 25'h0;
        else if (wr && paddr == 8'h00) ct <= pwdata[7:0];
        else if (wr && paddr == 8'h04) oe <= pwdata[7:0];
        else if (wr && paddr == 8'h08) ov <= pwdata[7:0];
        else if (wr && paddr == 8'h0c) sp <= pwdata[0];
    end
    wire [5:0] oe6 = {oe[6:4], oe[2:0]} & {6{sp}};
    wire [5:0] ov6 = {ov[6:4], ov[2:0]};
    wire ie_off = wr && paddr == 8'h28 && pwdata[7:0] == 8'h00;
    wire lo_drop = wr && (paddr == 8'h28 || paddr == 8'h2c && pwdata[0]);
    wire hi_drop = wr && (paddr == 8'h28 || paddr == 8'h2c && pwdata[1]);
    sequence held_off;
        !ct[0] && $stable(ov) ##1 !ct[0] && $stable(ov);
    endsequence
    sequence ie_cleared;
        ie_off;
    endsequence
    a_pad_follows_port: assert property (
        ((waveform_pin ^ port_out) & ~oe6) == 6'h00)
        else $error("pad left port value without enable");
    a_pin_shows_wave: assert property (
        ((waveform_pin ^ waveform_ccl) & oe6) == 6'h00)
        else $error("enabled pad not showing waveform");
    a_ccl_shows_value: assert property (
        held_off |-> waveform_ccl == ov6)
        else $error("idle waveform not equal to override value");
    a_cmd_reads_zero: assert property (
        rd && paddr inside {8'h10, 8'h14} |-> prdata[3:2] == 2'b00)
        else $error("command field read nonzero");
    a_upper_zero: assert property (
        rd |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits nonzero");
    a_unmapped_error: assert property (
        psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access without error");
    a_irq_masked: assert property (
        ie_cleared |=> {irq_low_compare, irq_high_underflow,
            irq_low_underflow} == 5'h00)
        else $error("interrupt line high with enables cleared");
    a_low_unf_sticky: assert property (
        $fell(irq_low_underflow) |-> $past(lo_drop))
        else $error("low underflow request dropped by itself");
    a_high_unf_sticky: assert property (
        $fell(irq_high_underflow) |-> $past(hi_drop))
        else $error("high underflow request dropped by itself");
endmodule : spt_checker

// ---- test/spt_port_model.sv ----
`timescale 1ns/100ps
module spt_port_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench side
    input wire logic [5:0] next_port,
    // Pin side
    output logic [5:0] port_out
);
    // Port register loads one edge late, as a real one would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) port_out <= 6'h00;
        else port_out <= next_port;
    end
endmodule : spt_port_model

// ---- test/test_split_timer_control.sv ----
`timescale 1ns/100ps
`include "spt_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
    miscompares++; $display("BAD %0t got %h want %h", $time, a, b); end end
module test_split_timer_control;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, want;
    logic [31:0] pwdata = 32'h0, prdata, st = 32'h16;
    logic pready, pslverr, irq_hu, irq_lu;
    logic [2:0] irq_lc;
    logic [5:0] next_port = 6'h00, port_out, pin, configurable_logic_block, e, v;
    logic [7:0] expq[$];
    int miscompares = 0, n_checks = 0;
    initial forever #25 pclk = ~pclk;
    spt_port_model spt_port_model_i (.pclk(pclk), .presetn(presetn),
        .next_port(next_port), .port_out(port_out));
    spt_split_timer_control spt_split_timer_control_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_out(port_out),
        .waveform_pin(pin), .waveform_ccl(configurable_logic_block), .irq_low_compare(irq_lc),
        .irq_high_underflow(irq_hu), .irq_low_underflow(irq_lu));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // For reads d is the expected value, queued for the monitor
    task apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        if (!w) expq.push_back(d);
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask : apb
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) begin
            want = expq.pop_front();
            `CHK(prdata[7:0], want)
        end
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        #(50 * 20000);
        miscompares++;
        end_of_test();
    end
    initial begin
        int i, c, en;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 12; i++) apb(0, i[5:0], 8'h00);
        apb(0, `SPT_IDX_LOW_PER, 8'hff);
        $display("test reset done");
        apb(1, `SPT_IDX_CMD_SET, 8'h03);
        apb(0, `SPT_IDX_CMD_SET, 8'h03);
        apb(1, `SPT_IDX_CMD_CLR, 8'h0d);
        apb(0, `SPT_IDX_CMD_CLR, 8'h02);
        for (c = 0; c < 4; c++) for (en = 0; en < 2; en++) begin
            apb(1, `SPT_IDX_LOW_PER, 8'h40);
            apb(1, `SPT_IDX_LOW_CNT, 8'h05);
            apb(1, `SPT_IDX_CTRL, en[7:0]);
            apb(1, `SPT_IDX_CMD_SET, {4'h0, c[1:0], 2'b11});
            apb(1, `SPT_IDX_CTRL, 8'h00);
            apb(0, `SPT_IDX_LOW_PER, (c == 3 && !en) ? 8'hff : 8'h40);
            apb(0, `SPT_IDX_LOW_CNT, c == 2 ? 8'h40 :
                (c == 3 && !en) ? 8'h00 : 8'h05);
            apb(0, `SPT_IDX_CMD_SET, 8'h03);
            apb(1, `SPT_IDX_CMD_CLR, 8'h03);
        end
        $display("test commands done");
        apb(1, `SPT_IDX_LOW_PER, 8'h03);
        apb(1, `SPT_IDX_HIGH_PER, 8'h03);
        apb(1, `SPT_IDX_LOW_CMP0, 8'h01);
        // Channel 2 compare is never reached, so its flag must stay clear
        apb(1, `SPT_IDX_LOW_CMP0 + 6'h04, 8'h09);
        apb(1, `SPT_IDX_MODE, 8'h01);
        apb(1, `SPT_IDX_INT_EN, 8'h73);
        apb(1, `SPT_IDX_CTRL, 8'h01);
        for (i = 0; i < 200 && !(irq_hu && irq_lu && &irq_lc[1:0]); i++)
            @(posedge pclk);
        apb(1, `SPT_IDX_CTRL, 8'h00);
        @(negedge pclk);
        `CHK({irq_lc, irq_hu, irq_lu}, 5'h0f)
        apb(0, `SPT_IDX_INT_FLAG, 8'h33);
        apb(1, `SPT_IDX_INT_FLAG, 8'h01);
        apb(0, `SPT_IDX_INT_FLAG, 8'h32);
        apb(1, `SPT_IDX_INT_EN, 8'h02);
        @(negedge pclk);
        `CHK({irq_lc, irq_hu, irq_lu}, 5'h02)
        apb(1, `SPT_IDX_INT_FLAG, 8'h73);
        apb(0, `SPT_IDX_INT_FLAG, 8'h00);
        $display("test flags done");
        apb(1, `SPT_IDX_LOW_CNT, 8'h80);
        // Restart with a reserved target must be ignored
        apb(1, `SPT_IDX_CMD_SET, 8'h09);
        apb(0, `SPT_IDX_CMD_SET, 8'h01);
        // Divide by 8 over 28 running cycles gives three ticks
        apb(1, `SPT_IDX_CTRL, 8'h07);
        repeat (25) @(posedge pclk);
        apb(1, `SPT_IDX_CTRL, 8'h00);
        apb(0, `SPT_IDX_LOW_CNT, 8'h7d);
        apb(1, `SPT_IDX_INT_EN, 8'h00);
        @(negedge pclk);
        `CHK({irq_lc, irq_hu, irq_lu}, 5'h00)
        $display("test prescaler done");
        repeat (8) begin
            @(posedge pclk);
            st = xs(st);
            next_port <= st[5:0];
            apb(1, `SPT_IDX_OUT_EN, st[15:8]);
            apb(1, `SPT_IDX_OUT_VAL, st[23:16]);
            @(posedge pclk);
            @(negedge pclk);
            e = {st[14:12], st[10:8]};
            v = {st[22:20], st[18:16]};
            `CHK(configurable_logic_block, v)
            `CHK(pin, (v & e) | (st[5:0] & ~e))
        end
        $display("test pins done");
        end_of_test();
    end
endmodule : test_split_timer_control
bind spt_split_timer_control spt_checker #(.CHANNELS(CHANNELS))
    spt_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pslverr(pslverr), .port_out(port_out),
    .waveform_pin(waveform_pin), .waveform_ccl(waveform_ccl),
    .irq_low_compare(irq_low_compare),
    .irq_high_underflow(irq_high_underflow),
    .irq_low_underflow(irq_low_underflow));
